// *** design/ldc_map.svh ***
// Register offsets, field positions, reset values and timing figures
// Assumes a 100 MHz protection clock and a word-aligned register map
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH
// ==========================================================
// Register byte offsets
`define LDC_ADR_CTRL      8'h00
`define LDC_ADR_NOM_LOC   8'h04
`define LDC_ADR_NOM_REM   8'h08
`define LDC_ADR_LINE_KM   8'h0c
`define LDC_ADR_CHAR_US   8'h10
`define LDC_ADR_LINE_RATE 8'h14
`define LDC_ADR_I_START   8'h18
`define LDC_ADR_S1_START  8'h1c
`define LDC_ADR_SLOPE1    8'h20
`define LDC_ADR_S2_START  8'h24
`define LDC_ADR_SLOPE2    8'h28
`define LDC_ADR_TX_BITS   8'h2c
`define LDC_ADR_STATUS    8'h30
// ==========================================================
// Control field positions
`define LDC_CTRL_EN       0
`define LDC_CTRL_GRP_LSB  1
`define LDC_CTRL_GRP_MSB  4
`define LDC_CTRL_HV       5
// Link bit positions
`define LDC_BIT_RTRIP     3
// ==========================================================
// Reset values (nominal currents in amperes, thresholds in per-unit Q8.8, slopes Q8 with 256 = 100 %)
`define LDC_RST_NOM       16'h03e8
`define LDC_RST_CHAR_US   16'h009d
`define LDC_RST_RATE      32'h0000fa00
`define LDC_RST_I_START   16'h0033
`define LDC_RST_S1_START  16'h0080
`define LDC_RST_SLOPE1    16'h0040
`define LDC_RST_S2_START  16'h0100
`define LDC_RST_SLOPE2    16'h0100
// ==========================================================
// Timing and arithmetic figures
`define LDC_CLK_MHZ       100
`define LDC_KM_US         5
`define LDC_LINK_TMO_MS   30
`define LDC_SYNC_WIN_US   20
`define LDC_DIV_LAST      5'd23
`define LDC_TRIP_COUNT    2'd2
`define LDC_ANG_HALF      16'h8000
`define LDC_ANG_30DEG     16'h1555
`define LDC_US_TO_ANG     839
`define LDC_COS_ONE       16'h4000
`endif

// *** design/ldc_pkg.sv ***
// Types shared by the comparator and its surroundings
// Assumes angles in 16-bit fractions of a turn, magnitudes in amperes
package ldc_pkg;
	// Three-phase phasor set, primary amperes and angle
	typedef struct packed {
		logic [2:0][15:0] mag;
		logic [2:0][15:0] ang;
	} phasor3_t;
	// One frame on the peer link
	typedef struct packed {
		phasor3_t    cur;
		logic [15:0] bits;
	} link_frame_t;
	// Task sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DIV  = 4'b0010,
		ST_CALC = 4'b0100,
		ST_SEND = 4'b1000
	} state_t;
endpackage

// *** design/line_differential_comparator.sv ***
// Per-phase line differential comparator with Wishbone register access
// Assumes the link framer delivers whole frames and the task tick is 10 ms
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.svh"
module line_differential_comparator #(
	parameter int unsigned LINK_TMO_CYC = `LDC_LINK_TMO_MS * 1000 * `LDC_CLK_MHZ,
	parameter int unsigned SYNC_WIN_CYC = `LDC_SYNC_WIN_US * `LDC_CLK_MHZ
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [7:0]          adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic [31:0]              dat_o,
	output logic                     ack_o,
	// Protection task side
	input  wire logic                task_tick_i,
	input  wire ldc_pkg::phasor3_t   local_i,
	input  wire logic                remote_trip_cmd_i,
	// Peer link frames
	input  wire logic                rx_valid_i,
	input  wire ldc_pkg::link_frame_t rx_frame_i,
	output logic                     tx_valid_o,
	output ldc_pkg::link_frame_t     tx_frame_o,
	// Matrix sources
	output logic [2:0]               diff_trip_o,
	output logic                     link_fail_o,
	output logic                     block_o,
	output logic                     peer_trip_o,
	output logic [15:0]              peer_bits_o
);
	import ldc_pkg::*;

	// ==========================================================
	// Helpers
	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
	// Parabolic cosine, Q2.14 signed; angle in turns
	function automatic logic signed [15:0] cosq(input logic [15:0] a);
		logic [15:0] u;
		logic [15:0] x;
		logic [31:0] sq;
		u = a[15] ? 16'(-a) : a;
		x = (u > `LDC_COS_ONE) ? 16'(`LDC_ANG_HALF - u) : u;
		sq = x * x;
		cosq = signed'(16'(`LDC_COS_ONE - 16'(sq >> 14)));
		if (u > `LDC_COS_ONE) begin
			cosq = -cosq;
		end
	endfunction
	// Threshold from bias: start level plus two slope segments
	function automatic logic [31:0] thr_of(input logic [15:0] b, input logic [15:0] st,
		input logic [15:0] s1s, input logic [15:0] k1, input logic [15:0] s2s,
		input logic [15:0] k2);
		logic [31:0] t;
		t = 32'(st);
		if (b > s1s) begin
			t = t + (32'((b > s2s ? s2s : b) - s1s) * 32'(k1) >> 8);
		end
		if (b > s2s) begin
			t = t + (32'(b - s2s) * 32'(k2) >> 8);
		end
		return t;
	endfunction

	// ==========================================================
	// Registers
	logic [31:0] ctrl_reg;                 // Enable, winding group, HV side
	logic [15:0] nom_loc_reg;              // Local nominal primary current
	logic [15:0] nom_rem_reg;              // Remote-end nominal primary current
	logic [7:0]  line_km_reg;              // Line length in km
	logic [15:0] char_us_reg;              // Link character time in us
	logic [31:0] line_rate_reg;            // Link rate in bit/s
	logic [15:0] i_start_reg, s1_start_reg, slope1_reg, s2_start_reg, slope2_reg;
	logic [15:0] tx_bits_reg;              // Software-driven outgoing bits
	logic        ack_reg;                  // Bus answer
	logic [31:0] rd_reg;                   // Read data
	logic [2:0]  trip_reg;                 // Per-phase differential trips
	logic        link_fail_reg, block_reg, aligned_reg;
	logic [15:0] peer_bits_reg;            // Binaries refreshed per task
	logic        tx_valid_reg;
	link_frame_t tx_frame_reg, rx_last_reg, rx_snap_reg;
	phasor3_t    loc_snap_reg;             // Local phasors held for one task
	state_t      state_reg;
	logic [2:0]  idx_reg;                  // Division item 0..5
	logic [1:0]  ph_reg;                   // Phase under comparison
	logic [4:0]  step_reg;                 // Divider step
	logic [23:0] num_reg;                  // Dividend, becomes quotient
	logic [16:0] rem_reg;                  // Partial remainder
	logic [15:0] norm_reg [0:5];           // Normalised magnitudes, Q8.8
	logic [1:0]  exc_reg [0:2];            // Consecutive exceed counts
	logic [23:0] since_tick_reg;           // Cycles since local task start
	logic [31:0] link_age_reg;             // Cycles since last peer frame

	// ==========================================================
	// Wishbone slave: one wait state, unmapped reads zero
	wire wb_req = cyc_i && stb_i && !ack_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rd_reg  <= 32'h0;
		end else begin
			ack_reg <= wb_req;
			if (adr_i == `LDC_ADR_CTRL) rd_reg <= ctrl_reg;
			else if (adr_i == `LDC_ADR_NOM_LOC) rd_reg <= 32'(nom_loc_reg);
			else if (adr_i == `LDC_ADR_NOM_REM) rd_reg <= 32'(nom_rem_reg);
			else if (adr_i == `LDC_ADR_LINE_KM) rd_reg <= 32'(line_km_reg);
			else if (adr_i == `LDC_ADR_CHAR_US) rd_reg <= 32'(char_us_reg);
			else if (adr_i == `LDC_ADR_LINE_RATE) rd_reg <= line_rate_reg;
			else if (adr_i == `LDC_ADR_I_START) rd_reg <= 32'(i_start_reg);
			else if (adr_i == `LDC_ADR_S1_START) rd_reg <= 32'(s1_start_reg);
			else if (adr_i == `LDC_ADR_SLOPE1) rd_reg <= 32'(slope1_reg);
			else if (adr_i == `LDC_ADR_S2_START) rd_reg <= 32'(s2_start_reg);
			else if (adr_i == `LDC_ADR_SLOPE2) rd_reg <= 32'(slope2_reg);
			else if (adr_i == `LDC_ADR_TX_BITS) rd_reg <= 32'(tx_bits_reg);
			else if (adr_i == `LDC_ADR_STATUS)
				rd_reg <= {peer_bits_reg, 10'h0, block_reg, aligned_reg, link_fail_reg, trip_reg};
			else rd_reg <= 32'h0;
		end
	end
	// Setting writes land on the answering edge
	wire wr = cyc_i && stb_i && we_i && ack_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg      <= 32'h0;
			nom_loc_reg   <= `LDC_RST_NOM;
			nom_rem_reg   <= `LDC_RST_NOM;
			line_km_reg   <= 8'h0;
			char_us_reg   <= `LDC_RST_CHAR_US;
			line_rate_reg <= `LDC_RST_RATE;
			i_start_reg   <= `LDC_RST_I_START;
			s1_start_reg  <= `LDC_RST_S1_START;
			slope1_reg    <= `LDC_RST_SLOPE1;
			s2_start_reg  <= `LDC_RST_S2_START;
			slope2_reg    <= `LDC_RST_SLOPE2;
			tx_bits_reg   <= 16'h0;
		end else if (wr) begin
			if (adr_i == `LDC_ADR_CTRL) ctrl_reg <= merge(ctrl_reg, dat_i, sel_i);
			else if (adr_i == `LDC_ADR_NOM_LOC) nom_loc_reg <= 16'(merge(32'(nom_loc_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_NOM_REM) nom_rem_reg <= 16'(merge(32'(nom_rem_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_LINE_KM) line_km_reg <= 8'(merge(32'(line_km_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_CHAR_US) char_us_reg <= 16'(merge(32'(char_us_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_LINE_RATE) line_rate_reg <= merge(line_rate_reg, dat_i, sel_i);
			else if (adr_i == `LDC_ADR_I_START) i_start_reg <= 16'(merge(32'(i_start_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_S1_START) s1_start_reg <= 16'(merge(32'(s1_start_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_SLOPE1) slope1_reg <= 16'(merge(32'(slope1_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_S2_START) s2_start_reg <= 16'(merge(32'(s2_start_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_SLOPE2) slope2_reg <= 16'(merge(32'(slope2_reg), dat_i, sel_i));
			else if (adr_i == `LDC_ADR_TX_BITS) tx_bits_reg <= 16'(merge(32'(tx_bits_reg), dat_i, sel_i));
		end
	end

	// ==========================================================
	// Channel delay and remote angle correction
	wire         en       = ctrl_reg[`LDC_CTRL_EN];
	wire [3:0]   grp      = ctrl_reg[`LDC_CTRL_GRP_MSB:`LDC_CTRL_GRP_LSB];
	wire [16:0]  delay_us = 17'(char_us_reg) + 17'(line_km_reg * `LDC_KM_US);
	wire [23:0]  delay_cy = 24'(delay_us * `LDC_CLK_MHZ);
	wire [15:0]  dly_ang  = 16'((32'(delay_us) * `LDC_US_TO_ANG) >> 8);
	wire [15:0]  grp_ang  = 16'(grp * `LDC_ANG_30DEG);
	// HV end sees the LV current lagging by the group angle
	wire [15:0]  grp_fix  = ctrl_reg[`LDC_CTRL_HV] ? grp_ang : 16'(-grp_ang);
	wire         go       = state_reg == ST_IDLE && task_tick_i && en;

	// ==========================================================
	// Per-phase comparison of the phase in ph_reg
	logic [15:0] a_n, b_n, bias, rem_ang;
	logic signed [15:0] cs;
	logic [31:0] thr;
	logic signed [49:0] d2;
	logic exceed;
	always_comb begin
		a_n     = norm_reg[{ph_reg, 1'b0}];
		b_n     = norm_reg[{ph_reg, 1'b1}];
		bias    = 16'((17'(a_n) + 17'(b_n)) >> 1);
		rem_ang = rx_snap_reg.cur.ang[ph_reg] + `LDC_ANG_HALF + dly_ang + grp_fix;
		cs      = cosq(loc_snap_reg.ang[ph_reg] - rem_ang);
		// Squared magnitude of the vector difference avoids a square root
		// Operands widened first so the squares cannot wrap at 16 bits
		d2 = signed'(50'(a_n) * 50'(a_n)) + signed'(50'(b_n) * 50'(b_n))
			- ((signed'(50'(a_n) * 50'(b_n)) * 50'(cs)) >>> 13);
		thr = thr_of(bias, i_start_reg, s1_start_reg, slope1_reg, s2_start_reg, slope2_reg);
		exceed = d2 > signed'(50'(thr) * 50'(thr));
	end

	// ==========================================================
	// Divider step for normalisation
	wire [16:0] rem_sh = {rem_reg[15:0], num_reg[23]};
	wire [16:0] den    = {1'b0, idx_reg[0] ? nom_rem_reg : nom_loc_reg};
	wire        qbit   = rem_sh >= den;
	wire [23:0] quo    = {num_reg[22:0], qbit};
	wire [2:0]  nxt    = idx_reg + 3'd1;
	function automatic logic [15:0] mag_sel(input logic [2:0] k);
		return k[0] ? rx_snap_reg.cur.mag[k[2:1]] : loc_snap_reg.mag[k[2:1]];
	endfunction

	// ==========================================================
	// Task sequencer: snapshot, six divisions, three phases, send
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			idx_reg   <= 3'd0;
			ph_reg    <= 2'd0;
			step_reg  <= 5'd0;
			num_reg   <= 24'h0;
			rem_reg   <= 17'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (go) begin
						state_reg <= ST_DIV;
						idx_reg   <= 3'd0;
						step_reg  <= 5'd0;
						rem_reg   <= 17'h0;
						num_reg   <= {local_i.mag[0], 8'h0};
					end
				end
				ST_DIV: begin
					rem_reg  <= qbit ? 17'(rem_sh - den) : rem_sh;
					num_reg  <= quo;
					step_reg <= step_reg + 5'd1;
					if (step_reg == `LDC_DIV_LAST) begin
						step_reg <= 5'd0;
						rem_reg  <= 17'h0;
						idx_reg  <= nxt;
						num_reg  <= {mag_sel(nxt), 8'h0};
						if (idx_reg == 3'd5) begin
							state_reg <= ST_CALC;
							ph_reg    <= 2'd0;
						end
					end
				end
				ST_CALC: begin
					ph_reg <= ph_reg + 2'd1;
					if (ph_reg == 2'd2) begin
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// Normalised results, saturated to 16 bits
	always_ff @(posedge clk_i) begin
		if (state_reg == ST_DIV && step_reg == `LDC_DIV_LAST) begin
			norm_reg[idx_reg] <= |quo[23:16] ? 16'hffff : quo[15:0];
		end
	end

	// ==========================================================
	// Snapshots and binary signals, refreshed once per task
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_last_reg   <= '0;
			rx_snap_reg   <= '0;
			loc_snap_reg  <= '0;
			peer_bits_reg <= 16'h0;
			peer_trip_o   <= 1'b0;
		end else begin
			if (rx_valid_i) rx_last_reg <= rx_frame_i;
			if (go) begin
				rx_snap_reg   <= rx_last_reg;
				loc_snap_reg  <= local_i;
				peer_bits_reg <= rx_last_reg.bits;
				peer_trip_o   <= rx_last_reg.bits[`LDC_BIT_RTRIP];
			end
		end
	end

	// ==========================================================
	// Link supervision and task alignment
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_age_reg   <= 32'h0;
			since_tick_reg <= 24'h0;
			link_fail_reg  <= 1'b0;
			aligned_reg    <= 1'b0;
			block_reg      <= 1'b0;
		end else begin
			link_age_reg   <= rx_valid_i ? 32'h0 : link_age_reg + 32'(link_age_reg < LINK_TMO_CYC);
			since_tick_reg <= task_tick_i ? 24'h0 : since_tick_reg + 24'(&since_tick_reg == 1'b0);
			link_fail_reg  <= en && link_age_reg >= LINK_TMO_CYC;
			block_reg      <= !en || link_fail_reg;
			// Peer frame leaves at its task start; judge arrival against delay
			if (link_fail_reg) aligned_reg <= 1'b0;
			else if (rx_valid_i)
				aligned_reg <= 32'(since_tick_reg) <= 32'(delay_cy) + SYNC_WIN_CYC;
		end
	end

	// ==========================================================
	// Trip decision and outgoing frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trip_reg <= 3'b0;
			for (int i = 0; i < 3; i++) exc_reg[i] <= 2'd0;
		end else if (block_reg) begin
			trip_reg <= 3'b0;
		end else if (state_reg == ST_CALC) begin
			exc_reg[ph_reg] <= !exceed ? 2'd0
				: (exc_reg[ph_reg] == `LDC_TRIP_COUNT ? `LDC_TRIP_COUNT : exc_reg[ph_reg] + 2'd1);
			trip_reg[ph_reg] <= aligned_reg && exceed
				&& exc_reg[ph_reg] + 2'd1 >= `LDC_TRIP_COUNT;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_valid_reg <= 1'b0;
			tx_frame_reg <= '0;
		end else begin
			tx_valid_reg <= state_reg == ST_SEND;
			if (state_reg == ST_SEND) begin
				tx_frame_reg.cur  <= loc_snap_reg;
				tx_frame_reg.bits <= {tx_bits_reg[15:4], remote_trip_cmd_i, trip_reg};
			end
		end
	end
	assign dat_o       = rd_reg;
	assign ack_o       = ack_reg;
	assign diff_trip_o = trip_reg;
	assign link_fail_o = link_fail_reg;
	assign block_o     = block_reg;
	assign peer_bits_o = peer_bits_reg;
	assign tx_valid_o  = tx_valid_reg;
	assign tx_frame_o  = tx_frame_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_task_start; go; endsequence
	sequence s_task_sent; tx_valid_reg; endsequence
	property p_task_done; s_task_start |-> ##[140:160] s_task_sent; endproperty
	a_task_done: assert property (p_task_done) else $error("task overran");
	property p_trip_aligned; |trip_reg |-> aligned_reg || $past(aligned_reg); endproperty
	a_trip_aligned: assert property (p_trip_aligned) else $error("trip unaligned");
	property p_fail_blocks; $rose(link_fail_reg) |=> block_reg ##1 trip_reg == 3'b0; endproperty
	a_fail_blocks: assert property (p_fail_blocks) else $error("no block");
	property p_two_cycles; $rose(trip_reg[0]) |-> exc_reg[0] == `LDC_TRIP_COUNT; endproperty
	a_two_cycles: assert property (p_two_cycles) else $error("early trip");
	property p_bits; go |=> peer_bits_reg == $past(rx_last_reg.bits); endproperty
	a_bits: assert property (p_bits) else $error("bits stale");
	property p_peer_trip; go |=> peer_trip_o == $past(rx_last_reg.bits[`LDC_BIT_RTRIP]); endproperty
	a_peer_trip: assert property (p_peer_trip) else $error("peer trip wrong");
	property p_tx_trip; tx_valid_reg && !block_reg |-> tx_frame_reg.bits[2:0] == trip_reg; endproperty
	a_tx_trip: assert property (p_tx_trip) else $error("tx trip mismatch");
	property p_ack; ack_reg |=> !ack_reg; endproperty
	a_ack: assert property (p_ack) else $error("ack held");
endmodule
`default_nettype wire

// *** verification/peer_relay_model.sv ***
// Behavioural model of the peer relay at the far end of the line
// Assumes it sees the local task tick, as the two ends run aligned tasks
`timescale 1ns/1ps
`default_nettype none
module peer_relay_model (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Task start and behaviour controls
	input  wire logic                 tick_i,
	input  wire logic                 silent_i,
	input  wire ldc_pkg::phasor3_t    cur_i,
	input  wire logic [15:0]          bits_i,
	// Frames towards the comparator
	output logic                      rx_valid_o,
	output ldc_pkg::link_frame_t      rx_frame_o
);
	import ldc_pkg::*;
	// ==========================================================
	// Frame sender
	logic [4:0] cnt_reg; // Cycles since our task start
	logic       run_reg; // Task in progress
	// One frame a task, a short while after the shared start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_reg    <= 1'b0;
			cnt_reg    <= 5'h00;
			rx_valid_o <= 1'b0;
			rx_frame_o <= '0;
		end else begin
			rx_valid_o <= 1'b0;
			// Released data is scrambled so stale values cannot pass
			if (rx_valid_o)
				rx_frame_o <= ~rx_frame_o;
			if (tick_i && !silent_i) begin
				run_reg <= 1'b1;
				cnt_reg <= 5'h00;
			end else if (run_reg) begin
				cnt_reg <= cnt_reg + 5'h01;
				// Primary currents plus binaries, silent when link is cut
				if (cnt_reg == 5'h13) begin
					run_reg    <= 1'b0;
					rx_valid_o <= 1'b1;
					rx_frame_o <= {cur_i, bits_i};
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the line differential comparator
// Assumes the peer model on the link and Wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.svh"
module tb;
	import ldc_pkg::*;
	// ==========================================================
	// Signals
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        tick = 1'b0, cmd = 1'b0, silent = 1'b1, rd_pend = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	phasor3_t    loc = '0, rem = '0;
	link_frame_t rxf, txf;
	logic        rxv, txv, ack, lf, blk, ptrip;
	logic [2:0]  trip;
	logic [15:0] pbits, txreg;
	int          fails = 0, n_compared = 0, cyc_cnt = 0, n;
	// Expected send contents, noted by the task driver
	typedef struct {logic [2:0] trip; logic [15:0] bits; logic peer;} exp_t;
	exp_t        tq[$], e;
	logic [31:0] rq[$];
	localparam logic [15:0] PEER_BITS = 16'h5a3c; // Remote trip bit set
	always #5 clk = ~clk;
	// ==========================================================
	// Design and far end
	line_differential_comparator #(.LINK_TMO_CYC(500)) dut (
		.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .task_tick_i(tick),
		.local_i(loc), .remote_trip_cmd_i(cmd), .rx_valid_i(rxv), .rx_frame_i(rxf),
		.tx_valid_o(txv), .tx_frame_o(txf), .diff_trip_o(trip), .link_fail_o(lf),
		.block_o(blk), .peer_trip_o(ptrip), .peer_bits_o(pbits));
	peer_relay_model peer (.clk_i(clk), .rst_i(rst), .tick_i(tick), .silent_i(silent),
		.cur_i(rem), .bits_i(PEER_BITS), .rx_valid_o(rxv), .rx_frame_o(rxf));
	// ==========================================================
	// Tasks
	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Classic single cycle; holds until ack seen at a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		rd_pend <= !w;
		if (!w)
			rq.push_back(d);
		// Ack sampled at the rising edge; release only after it
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		rd_pend <= 1'b0;
	endtask
	// One protection task; spacing well above the minimum of 149 cycles
	task automatic run_task(input logic [2:0] t, input logic pr);
		logic c;
		exp_t x;
		c = 1'($urandom_range(1));
		x = '{t, {txreg[15:4], c, t}, pr};
		tq.push_back(x);
		@(posedge clk);
		tick <= 1'b1;
		cmd <= c;
		@(posedge clk);
		tick <= 1'b0;
		repeat (298) @(posedge clk);
	endtask
	// Three phases a third of a turn apart, with a common offset
	function automatic phasor3_t mk(input logic [15:0] m, input logic [15:0] off);
		for (int p = 0; p < 3; p++) begin
			mk.mag[p] = m;
			mk.ang[p] = 16'(p * 16'h5555) + off;
		end
	endfunction
	// ==========================================================
	// Output watcher: oldest note against each result
	// Read data taken at the edge where ack is sampled high
	always @(posedge clk) begin
		if (ack === 1'b1 && rd_pend)
			check("read data", rdat, rq.pop_front());
	end
	always @(negedge clk) begin
		if (txv) begin
			if (tq.size() == 0)
				check("unexpected send", 1'b1, 1'b0);
			else begin
				e = tq.pop_front();
				check("diff trip", trip, e.trip);
				check("sent binaries", txf.bits, e.bits);
				check("sent currents", txf.cur, loc);
				if (e.peer) begin
					check("peer binaries", pbits, PEER_BITS);
					check("peer trip", ptrip, 1'b1);
				end
			end
		end
	end
	// Hang guard
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h68cad126));
		txreg = 16'($urandom);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("reset outputs", {trip, lf, blk, ptrip, pbits, txv, ack}, 0);
		wb(1'b0, `LDC_ADR_CHAR_US, {16'h0, `LDC_RST_CHAR_US});
		wb(1'b0, `LDC_ADR_LINE_RATE, `LDC_RST_RATE);
		wb(1'b0, `LDC_ADR_NOM_REM, {16'h0, `LDC_RST_NOM});
		wb(1'b0, 8'h3c, 32'h0);
		wb(1'b1, `LDC_ADR_NOM_REM, 32'h12c);
		wb(1'b0, `LDC_ADR_NOM_REM, 32'h12c);
		wb(1'b1, `LDC_ADR_TX_BITS, {16'h0, txreg});
		// Healthy load: 1000 A locally, 300 A at the far end, reversed
		@(posedge clk);
		loc <= mk(16'd1000, 16'h0);
		rem <= mk(16'd300, 16'h8000);
		silent <= 1'b0;
		wb(1'b1, `LDC_ADR_CTRL, 32'h1);
		run_task(3'b000, 1'b0);
		repeat (3) run_task(3'b000, 1'b1);
		// Internal fault fed from the far end; old frame used first
		@(posedge clk);
		rem <= mk(16'd2100, 16'h0);
		run_task(3'b000, 1'b1);
		run_task(3'b000, 1'b1);
		run_task(3'b111, 1'b1);
		// Half-turn winding group on the HV side: in-phase remote is healthy
		@(posedge clk);
		rem <= mk(16'd300, 16'h0);
		wb(1'b1, `LDC_ADR_CTRL, 32'h2d);
		run_task(3'b111, 1'b1);
		run_task(3'b000, 1'b1);
		// Cut the link and wait for the failure flag
		@(posedge clk);
		silent <= 1'b1;
		for (n = 0; n < 700 && lf !== 1'b1; n++)
			@(negedge clk);
		check("link fail", lf, 1'b1);
		repeat (3) @(negedge clk);
		check("block and trip", {blk, trip}, {1'b1, 3'b000});
		check("pending sends", tq.size(), 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
